// ==== include/lbs_pkg.sv ====
// Package of constants and types for the low battery supervisor.
// Functional notes
// - The voltage monitor keeps running in every powered activity state.
// - The low battery threshold is a software setting used as trip level.
// - The comparator result passes hysteresis and a selectable debounce.
// - A low battery event is raised when the filtered voltage drops below.
// - With no host standby within eight seconds the device forces standby.
// - The low battery event clears on every active to standby transition.
// - Reading the status clears it, and events during the read are kept.
// - A masked event does not assert the interrupt but stays visible.
// - The active-low interrupt is asserted in active state when unmasked.
package lbs_pkg;
    // ------------------------------------------------------------
    // Timing
    // ------------------------------------------------------------
    localparam int CLK_HZ = 40000000;
    localparam int FORCE_TIMEOUT_S = 8;
    localparam longint FORCE_CYC_L = longint'(FORCE_TIMEOUT_S) * CLK_HZ;
    localparam int FORCE_CYC = int'(FORCE_CYC_L);
    localparam int TICK_HZ = 1000;
    localparam int TICK_DIV = CLK_HZ / TICK_HZ;
    localparam int THR_W = 8;
    localparam int HYST_W = 4;
    localparam logic [3:0] HYST_DEF = 4'h2;
    localparam logic [THR_W-1:0] THR_DEF = 8'h80;
    // ------------------------------------------------------------
    // Debounce selections, in slow ticks
    // ------------------------------------------------------------
    localparam logic [1:0] DEB_OFF = 2'h0;
    localparam logic [7:0] DEB_T1 = 8'h08;
    localparam logic [7:0] DEB_T2 = 8'h20;
    localparam logic [7:0] DEB_T3 = 8'h3E;
    // ------------------------------------------------------------
    // Types
    // ------------------------------------------------------------
    typedef enum logic [1:0] {
        ST_SAVE = 2'b00,
        ST_STANDBY = 2'b01,
        ST_ACTIVE = 2'b10
    } lbs_state_t;
    typedef struct packed {
        logic [THR_W-1:0] threshold;
        logic [HYST_W-1:0] hyst;
        logic [1:0] deb_sel;
        logic mask;
    } lbs_cfg_t;
endpackage

// ==== core/lbs_debounce.sv ====
// Debounce filter for the hysteretic low battery comparator level.
`timescale 1ns/1ps
module lbs_debounce (
    // Clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // Control
    input wire logic i_tick,
    input wire logic [7:0] i_len,
    input wire logic i_raw,
    // Result
    output logic o_filt
);
    logic [7:0] cnt_q;
    logic filt_q;

    // ------------------------------------------------------------
    // Filter counter
    // ------------------------------------------------------------
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            cnt_q <= 8'h00;
            filt_q <= 1'b0;
        end else if (i_raw == filt_q) begin
            cnt_q <= 8'h00;
        end else if (i_len == 8'h00) begin
            filt_q <= i_raw;
        end else if (i_tick) begin
            if (cnt_q + 8'h01 >= i_len) begin
                filt_q <= i_raw;
                cnt_q <= 8'h00;
            end else begin
                cnt_q <= cnt_q + 8'h01;
            end
        end
    end
    assign o_filt = filt_q;

    a_filter_holds: assert property (@(posedge clk) disable iff (!rst_n)
        (i_len != 8'h00 && !i_tick && i_raw != filt_q) |=> $stable(filt_q))
        else $error("Filter moved without a tick.");
endmodule

// ==== core/lbs_top.sv ====
// Low battery supervisor: filter, event, interrupt and forced standby.
`timescale 1ns/1ps
module lbs_top #(
    parameter int FORCE_CYCLES = lbs_pkg::FORCE_CYC,
    parameter int TICK_CYCLES = lbs_pkg::TICK_DIV
) (
    // Clock and reset
    input wire logic I_REF_CLK,
    input wire logic I_NRST,
    // Analog side and configuration
    input wire logic [lbs_pkg::THR_W-1:0] I_BAT_LEVEL,
    input wire lbs_pkg::lbs_cfg_t I_CFG,
    // Device state
    input wire lbs_pkg::lbs_state_t I_STATE,
    input wire logic I_HOST_STANDBY,
    // Status read
    input wire logic I_STATUS_RD,
    output logic O_STATUS,
    // Outputs
    output logic O_IRQ_N,
    output logic O_FORCE_STANDBY,
    output logic O_BELOW
);
    logic rst_m_q;
    logic rst_s_q;
    logic [15:0] div_q;
    logic tick;
    logic below_raw_q;
    logic below_filt;
    logic filt_prev_q;
    logic evt;
    logic status_q;
    logic hold_q;
    logic rd_prev_q;
    logic [31:0] tmo_q;
    logic tmo_run_q;
    logic force_q;
    logic [7:0] deb_len;
    logic act_to_stb;
    lbs_pkg::lbs_state_t state_prev_q;

    function automatic logic [7:0] deb_decode(input logic [1:0] sel);
        case (sel)
            2'h1: deb_decode = lbs_pkg::DEB_T1;
            2'h2: deb_decode = lbs_pkg::DEB_T2;
            2'h3: deb_decode = lbs_pkg::DEB_T3;
            default: deb_decode = 8'h00;
        endcase
    endfunction

    // ------------------------------------------------------------
    // Reset release
    // ------------------------------------------------------------
    always_ff @(posedge I_REF_CLK or negedge I_NRST) begin
        if (!I_NRST) begin
            rst_m_q <= 1'b0;
            rst_s_q <= 1'b0;
        end else begin
            rst_m_q <= 1'b1;
            rst_s_q <= rst_m_q;
        end
    end

    // ------------------------------------------------------------
    // Slow tick divider, free in every state
    // ------------------------------------------------------------
    always_ff @(posedge I_REF_CLK or negedge rst_s_q) begin
        if (!rst_s_q) begin
            div_q <= 16'h0000;
        end else if (div_q == 16'(TICK_CYCLES - 1)) begin
            div_q <= 16'h0000;
        end else begin
            div_q <= div_q + 16'h0001;
        end
    end
    assign tick = (div_q == 16'(TICK_CYCLES - 1));

    // ------------------------------------------------------------
    // Comparator with hysteresis, active in all states
    // ------------------------------------------------------------
    always_ff @(posedge I_REF_CLK or negedge rst_s_q) begin
        if (!rst_s_q) begin
            below_raw_q <= 1'b0;
        end else if (!below_raw_q) begin
            below_raw_q <= (I_BAT_LEVEL < I_CFG.threshold);
        end else begin
            below_raw_q <= ({1'b0, I_BAT_LEVEL} <
                ({1'b0, I_CFG.threshold} + {5'h00, I_CFG.hyst}));
        end
    end

    assign deb_len = deb_decode(I_CFG.deb_sel);

    lbs_debounce u_deb (
        .clk(I_REF_CLK),
        .rst_n(rst_s_q),
        .i_tick(tick),
        .i_len(deb_len),
        .i_raw(below_raw_q),
        .o_filt(below_filt)
    );

    // ------------------------------------------------------------
    // Event, status and read clear
    // ------------------------------------------------------------
    always_ff @(posedge I_REF_CLK or negedge rst_s_q) begin
        if (!rst_s_q) begin
            filt_prev_q <= 1'b0;
            state_prev_q <= lbs_pkg::ST_SAVE;
            rd_prev_q <= 1'b0;
        end else begin
            filt_prev_q <= below_filt;
            state_prev_q <= I_STATE;
            rd_prev_q <= I_STATUS_RD;
        end
    end
    assign evt = below_filt && !filt_prev_q;
    assign act_to_stb = (state_prev_q == lbs_pkg::ST_ACTIVE) &&
        (I_STATE != lbs_pkg::ST_ACTIVE);

    always_ff @(posedge I_REF_CLK or negedge rst_s_q) begin
        if (!rst_s_q) begin
            status_q <= 1'b0;
            hold_q <= 1'b0;
        end else if (act_to_stb) begin
            status_q <= 1'b0;
            hold_q <= 1'b0;
        end else if (I_STATUS_RD) begin
            hold_q <= hold_q | evt;
        end else if (rd_prev_q) begin
            status_q <= hold_q | evt;
            hold_q <= 1'b0;
        end else if (evt) begin
            status_q <= 1'b1;
        end
    end
    assign O_STATUS = status_q;

    // ------------------------------------------------------------
    // Interrupt output
    // ------------------------------------------------------------
    assign O_IRQ_N = !(status_q && !I_CFG.mask &&
        I_STATE == lbs_pkg::ST_ACTIVE);

    // ------------------------------------------------------------
    // Forced standby timeout
    // ------------------------------------------------------------
    always_ff @(posedge I_REF_CLK or negedge rst_s_q) begin
        if (!rst_s_q) begin
            tmo_q <= 32'h00000000;
            tmo_run_q <= 1'b0;
            force_q <= 1'b0;
        end else if (I_HOST_STANDBY || act_to_stb) begin
            tmo_run_q <= 1'b0;
            tmo_q <= 32'h00000000;
            force_q <= 1'b0;
        end else if (evt && I_STATE == lbs_pkg::ST_ACTIVE && !tmo_run_q) begin
            tmo_run_q <= 1'b1;
            tmo_q <= 32'h00000000;
        end else if (tmo_run_q) begin
            if (tmo_q == 32'(FORCE_CYCLES - 1)) begin
                force_q <= 1'b1;
                tmo_run_q <= 1'b0;
            end else begin
                tmo_q <= tmo_q + 32'h00000001;
            end
        end
    end
    assign O_FORCE_STANDBY = force_q;
    assign O_BELOW = below_filt;

    // ------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------
    a_clear_on_stby: assert property (@(posedge I_REF_CLK)
        disable iff (!rst_s_q) act_to_stb |=> !status_q)
        else $error("Status not cleared on standby entry.");
    a_event_sets: assert property (@(posedge I_REF_CLK)
        disable iff (!rst_s_q)
        (evt && !I_STATUS_RD && !rd_prev_q && !act_to_stb) |=> status_q)
        else $error("Event did not set status.");
    a_read_clears: assert property (@(posedge I_REF_CLK)
        disable iff (!rst_s_q)
        (rd_prev_q && !I_STATUS_RD && !evt && !hold_q && !act_to_stb)
        |=> !status_q)
        else $error("Read did not clear status.");
    a_read_keeps: assert property (@(posedge I_REF_CLK)
        disable iff (!rst_s_q)
        (I_STATUS_RD && evt && !act_to_stb) |=> hold_q)
        else $error("Event during read lost.");
    a_mask_quiet: assert property (@(posedge I_REF_CLK)
        disable iff (!rst_s_q) I_CFG.mask |-> O_IRQ_N)
        else $error("Masked event asserted interrupt.");
    a_irq_active: assert property (@(posedge I_REF_CLK)
        disable iff (!rst_s_q)
        (status_q && !I_CFG.mask && I_STATE == lbs_pkg::ST_ACTIVE)
        |-> !O_IRQ_N)
        else $error("Interrupt missing while pending.");
    a_cancel_tmo: assert property (@(posedge I_REF_CLK)
        disable iff (!rst_s_q) I_HOST_STANDBY |=> !tmo_run_q && !force_q)
        else $error("Timeout not cancelled.");
    a_force_time: assert property (@(posedge I_REF_CLK)
        disable iff (!rst_s_q) $rose(force_q) |-> $past(tmo_run_q))
        else $error("Force without running timeout.");
    a_below_mon: assert property (@(posedge I_REF_CLK)
        disable iff (!rst_s_q)
        (!below_raw_q && I_BAT_LEVEL < I_CFG.threshold) |=> below_raw_q)
        else $error("Comparator missed drop.");

    c_event: cover property (@(posedge I_REF_CLK) disable iff (!rst_s_q) evt);
    c_force: cover property (@(posedge I_REF_CLK) disable iff (!rst_s_q)
        $rose(force_q));
    c_read_evt: cover property (@(posedge I_REF_CLK) disable iff (!rst_s_q)
        I_STATUS_RD && evt);
endmodule

// ==== sim/lbs_host_model.sv ====
// Host controller model that answers the interrupt with a standby request.
`timescale 1ns/1ps
module lbs_host_model (
    // Clock
    input wire logic clk,
    // Control
    input wire logic i_irq_n,
    input wire logic i_enable,
    input wire logic [7:0] i_delay,
    // Request
    output logic o_standby
);
    int cnt;
    // Pulses a standby request a set delay after the interrupt goes low.
    always @(negedge clk) begin
        o_standby <= 1'b0;
        if (i_enable && i_irq_n === 1'b0) begin
            cnt <= cnt + 1;
            if (cnt == int'(i_delay)) begin
                o_standby <= 1'b1;
            end
        end else begin
            cnt <= 0;
        end
    end
endmodule

// ==== sim/low_battery_supervisor_tb.sv ====
// Self-checking bench for the low battery supervisor.
`timescale 1ns/1ps
module low_battery_supervisor_tb;
    logic clk, nrst, rd, hstby, host_en;
    logic [7:0] lvl;
    lbs_pkg::lbs_cfg_t cfg;
    lbs_pkg::lbs_state_t st;
    logic o_status, o_irq_n, o_force, o_below;
    int fail_count, tests_run, exp_below, exp_stat;
    lbs_top #(.FORCE_CYCLES(200), .TICK_CYCLES(10)) dut (
        .I_REF_CLK(clk), .I_NRST(nrst), .I_BAT_LEVEL(lvl), .I_CFG(cfg),
        .I_STATE(st), .I_HOST_STANDBY(hstby), .I_STATUS_RD(rd),
        .O_STATUS(o_status), .O_IRQ_N(o_irq_n), .O_FORCE_STANDBY(o_force),
        .O_BELOW(o_below));
    lbs_host_model host (.clk(clk), .i_irq_n(o_irq_n), .i_enable(host_en),
        .i_delay(8'h14), .o_standby(hstby));
    // ------------------------------------------------------------
    // Tasks
    // ------------------------------------------------------------
    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        tests_run++;
        if (seen !== exp) begin
            fail_count++;
            $display("wrong value at %0t: %0h expected %0h", $time, seen,
                exp);
        end
    endtask
    task automatic cyc(input int n);
        repeat (n) @(negedge clk);
    endtask
    // Sets the level and moves the model through hysteresis and events.
    task automatic level(input logic [7:0] v);
        lvl = v;
        if (int'(v) < int'(cfg.threshold)) begin
            if (exp_below == 0) exp_stat = 1;
            exp_below = 1;
        end else if (int'(v) >= int'(cfg.threshold) + int'(cfg.hyst)) begin
            exp_below = 0;
        end
        cyc(4);
    endtask
    task automatic check_all();
        logic e_irq;
        e_irq = (exp_stat != 0 && !cfg.mask && st == lbs_pkg::ST_ACTIVE)
            ? 1'b0 : 1'b1;
        check(o_below, 8'(exp_below));
        check(o_status, 8'(exp_stat));
        check(o_irq_n, 8'(e_irq));
    endtask
    task automatic read_clear();
        rd = 1'b1;
        cyc(1);
        rd = 1'b0;
        exp_stat = 0;
        cyc(3);
    endtask
    task automatic final_report();
        if (fail_count == 0 && tests_run > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask
    // ------------------------------------------------------------
    // Clock, watchdog and tests
    // ------------------------------------------------------------
    initial begin
        clk = 1'b0;
        forever #12.5 clk = ~clk;
    end
    initial begin
        #200000;
        fail_count++;
        final_report();
    end
    initial begin
        nrst = 1'b0;
        rd = 1'b0;
        host_en = 1'b0;
        lvl = 8'hFF;
        st = lbs_pkg::ST_STANDBY;
        cfg = '{threshold: lbs_pkg::THR_DEF, hyst: lbs_pkg::HYST_DEF,
            deb_sel: lbs_pkg::DEB_OFF, mask: 1'b0};
        fail_count = 0;
        tests_run = 0;
        exp_below = 0;
        exp_stat = 0;
        void'($urandom(10445));
        cyc(20);
        nrst = 1'b1;
        cyc(3);
        check_all();
        check(o_force, 8'h00);
        // Random levels around the trip point while in standby.
        for (int k = 0; k < 24; k++) begin
            level(8'h7A + 8'($urandom_range(0, 9)));
            check_all();
            if (exp_stat != 0) begin
                read_clear();
                check_all();
            end
        end
        // An event during a read survives the clear.
        level(8'hFF);
        rd = 1'b1;
        level(8'h70);
        rd = 1'b0;
        cyc(3);
        check_all();
        read_clear();
        level(8'hFF);
        // Masked then unmasked event in active, then the forced standby.
        st = lbs_pkg::ST_ACTIVE;
        cfg.mask = 1'b1;
        level(8'h70);
        check_all();
        cfg.mask = 1'b0;
        cyc(2);
        check_all();
        cyc(180);
        check(o_force, 8'h00);
        cyc(30);
        check(o_force, 8'h01);
        st = lbs_pkg::ST_STANDBY;
        exp_stat = 0;
        cyc(3);
        check_all();
        check(o_force, 8'h00);
        // The host answers in time and the timeout is cancelled.
        level(8'hFF);
        st = lbs_pkg::ST_ACTIVE;
        host_en = 1'b1;
        level(8'h70);
        cyc(240);
        check(o_force, 8'h00);
        st = lbs_pkg::ST_STANDBY;
        host_en = 1'b0;
        exp_stat = 0;
        level(8'hFF);
        check_all();
        // A drop longer than the shortest debounce passes the filter.
        cfg.deb_sel = 2'h1;
        lvl = 8'h70;
        cyc(60);
        check(o_below, 8'h00);
        cyc(40);
        check(o_below, 8'h01);
        check(o_status, 8'h01);
        lvl = 8'hFF;
        cyc(100);
        check(o_below, 8'h00);
        // Dips shorter than the longer debounce times are ignored.
        for (int s = 2; s < 4; s++) begin
            cfg.deb_sel = 2'(s);
            lvl = 8'h70;
            cyc((s - 1) * 250);
            lvl = 8'hFF;
            cyc(20);
            check(o_below, 8'h00);
        end
        final_report();
    end
endmodule
